/* common/cmpctl_cfg.svh */
// offsets, field positions and reset values of the comparator control block
`ifndef CMPCTL_CFG_SVH
`define CMPCTL_CFG_SVH
`define CMPCTL_ADR_CONTROL     4'h0
`define CMPCTL_ADR_IRQ_STATUS  4'h4
`define CMPCTL_ADR_IRQ_MASK    4'h8
`define CMPCTL_BIT_ENABLE      15
`define CMPCTL_BIT_PIN_EN      14
`define CMPCTL_BIT_INVERT      13
`define CMPCTL_BIT_AMP_MODE    10
`define CMPCTL_BIT_EVENT       9
`define CMPCTL_BIT_RESULT      8
`define CMPCTL_BIT_EVPOL_HI    7
`define CMPCTL_BIT_EVPOL_LO    6
`define CMPCTL_BIT_REF_SEL     4
`define CMPCTL_BIT_CHAN_HI     1
`define CMPCTL_BIT_CHAN_LO     0
`define CMPCTL_CTRL_WMASK      16'hE4D3
`define CMPCTL_CTRL_RESET      16'h0000
`define CMPCTL_CHAN_AVAIL      4'hF
`define CMPCTL_REF_AVAIL       2'h3
`endif

/* common/cmpctl_pkg.sv */
// types of the comparator control block
package cmpctl_pkg;
    typedef enum logic [1:0] {
        CMPCTL_EV_NONE,
        CMPCTL_EV_RISE,
        CMPCTL_EV_FALL,
        CMPCTL_EV_BOTH
    } cmpctl_evpol_t;

    typedef struct packed {
        logic       unit_enable;
        logic       output_pin_enable;
        logic       output_invert;
        logic       amplifier_mode_select;
        logic [1:0] event_polarity;
        logic       reference_select;
        logic [1:0] channel_select;
    } cmpctl_cfg_t;

    typedef struct packed {
        logic       analog_enable;
        logic       amp_mode;
        logic [1:0] inv_input_sel;
        logic       inv_input_gnd;
        logic       noninv_ref_sel;
        logic       noninv_input_gnd;
        logic       adc_use_amp;
    } cmpctl_analog_t;

    typedef struct packed {
        logic [3:0]  adr;
        logic [15:0] dat;
        logic [1:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } cmpctl_wb_req_t;
endpackage

/* design/cmpctl_top.sv */
// comparator / op amp channel control with wishbone registers
//
// Behaviour
// - enable bit switches analog circuit on/off
// - pin enable routes result to output pin
// - amplifier mode blocks the output pin
// - invert bit inverts comparator output
// - mode bit selects op amp or comparator
// - event latches, blocks triggers until cleared
// - result bit reports polarity-adjusted comparison
// - unavailable selected inputs tie to ground
// - adc scan takes amplifier output in amp mode
// - bits 12 to 11 read zero
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cmpctl_cfg.svh"

module cmpctl_top (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    input  wire cmpctl_pkg::cmpctl_wb_req_t i_wb,
    output logic [15:0]                  o_wb_dat,
    output logic                         o_wb_ack,
    input  wire logic                    i_cmp_raw,
    output logic                         o_comparator_output_pin,
    output logic                         o_trigger,
    output logic                         o_irq,
    output cmpctl_pkg::cmpctl_analog_t   o_analog
);
    import cmpctl_pkg::*;

    logic [15:0]    ctrl;
    logic           sync1;
    logic           sync2;
    logic           result_q;
    logic           event_q;
    logic           irq_status;
    logic           irq_mask;
    logic           access;
    logic           wr_ctrl;
    logic           wr_stat;
    logic           wr_mask;
    logic           hit;
    logic           cmp_now;
    logic           edge_hit;
    logic           next_event;
    logic           next_status;
    logic [15:0]    next_rdata;
    cmpctl_cfg_t    cfg;
    cmpctl_analog_t next_analog;

    // input availability; selections outside these tie to ground
    function automatic logic chan_missing(input logic [1:0] ch);
        logic [3:0] avail;
        avail = `CMPCTL_CHAN_AVAIL;
        return ~avail[ch];
    endfunction

    function automatic logic ref_missing(input logic rs);
        logic [1:0] avail;
        avail = `CMPCTL_REF_AVAIL;
        return ~avail[rs];
    endfunction

    assign cfg.unit_enable           = ctrl[`CMPCTL_BIT_ENABLE];
    assign cfg.output_pin_enable     = ctrl[`CMPCTL_BIT_PIN_EN];
    assign cfg.output_invert         = ctrl[`CMPCTL_BIT_INVERT];
    assign cfg.amplifier_mode_select = ctrl[`CMPCTL_BIT_AMP_MODE];
    assign cfg.event_polarity        = ctrl[`CMPCTL_BIT_EVPOL_HI:`CMPCTL_BIT_EVPOL_LO];
    assign cfg.reference_select      = ctrl[`CMPCTL_BIT_REF_SEL];
    assign cfg.channel_select        = ctrl[`CMPCTL_BIT_CHAN_HI:`CMPCTL_BIT_CHAN_LO];

    // a single-cycle slave; ack low in the cycle after it was given
    assign access  = i_wb.cyc & i_wb.stb & ~o_wb_ack;
    assign wr_ctrl = access & i_wb.we & (i_wb.adr == `CMPCTL_ADR_CONTROL);
    assign wr_stat = access & i_wb.we & (i_wb.adr == `CMPCTL_ADR_IRQ_STATUS);
    assign wr_mask = access & i_wb.we & (i_wb.adr == `CMPCTL_ADR_IRQ_MASK);

    // the comparator output crosses from the analog domain
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= i_cmp_raw;
            sync2 <= sync1;
        end
    end

    // comparator off or in amp mode gives a steady low result
    assign cmp_now = cfg.unit_enable & ~cfg.amplifier_mode_select
                   & (sync2 ^ cfg.output_invert);

    always_comb begin
        case (cmpctl_evpol_t'(cfg.event_polarity))
            CMPCTL_EV_NONE: edge_hit = 1'b0;
            CMPCTL_EV_RISE: edge_hit = cmp_now & ~result_q;
            CMPCTL_EV_FALL: edge_hit = ~cmp_now & result_q;
            CMPCTL_EV_BOTH: edge_hit = cmp_now ^ result_q;
            default:        edge_hit = 1'b0;
        endcase
    end

    assign hit = edge_hit & ~event_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            result_q <= 1'b0;
        end else begin
            result_q <= cmp_now;
        end
    end

    // event flag: software may clear by writing zero, the set wins
    always_comb begin
        next_event = event_q;
        if (wr_ctrl && i_wb.sel[1] && !i_wb.dat[`CMPCTL_BIT_EVENT]) begin
            next_event = 1'b0;
        end
        if (hit) begin
            next_event = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            event_q <= 1'b0;
        end else begin
            event_q <= next_event;
        end
    end

    // writable control bits; reserved 12:11 never store
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl <= `CMPCTL_CTRL_RESET;
        end else if (wr_ctrl) begin
            if (i_wb.sel[0]) begin
                ctrl[7:0] <= i_wb.dat[7:0] & 8'(`CMPCTL_CTRL_WMASK);
            end
            if (i_wb.sel[1]) begin
                ctrl[15:8] <= i_wb.dat[15:8] & 8'(`CMPCTL_CTRL_WMASK >> 8);
            end
        end
    end

    // interrupt status: write one to clear, a new event wins
    always_comb begin
        next_status = irq_status;
        if (wr_stat && i_wb.sel[0] && i_wb.dat[0]) begin
            next_status = 1'b0;
        end
        if (hit) begin
            next_status = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_status <= 1'b0;
            irq_mask   <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_mask && i_wb.sel[0]) begin
                irq_mask <= i_wb.dat[0];
            end
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (i_wb.adr)
            `CMPCTL_ADR_CONTROL: begin
                next_rdata = ctrl;
                next_rdata[`CMPCTL_BIT_EVENT]  = event_q;
                next_rdata[`CMPCTL_BIT_RESULT] = result_q;
            end
            `CMPCTL_ADR_IRQ_STATUS: next_rdata[0] = irq_status;
            `CMPCTL_ADR_IRQ_MASK:   next_rdata[0] = irq_mask;
            default:                next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 16'h0000;
        end else begin
            o_wb_ack <= access;
            o_wb_dat <= access ? next_rdata : 16'h0000;
        end
    end

    // analog steering
    always_comb begin
        next_analog.analog_enable    = cfg.unit_enable;
        next_analog.amp_mode         = cfg.amplifier_mode_select;
        next_analog.inv_input_sel    = cfg.channel_select;
        next_analog.inv_input_gnd    = chan_missing(cfg.channel_select);
        next_analog.noninv_ref_sel   = cfg.reference_select;
        next_analog.noninv_input_gnd = ref_missing(cfg.reference_select);
        next_analog.adc_use_amp      = cfg.amplifier_mode_select;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_analog                <= '0;
            o_comparator_output_pin <= 1'b0;
            o_trigger               <= 1'b0;
            o_irq                   <= 1'b0;
        end else begin
            o_analog <= next_analog;
            o_comparator_output_pin <= cfg.output_pin_enable
                                     & ~cfg.amplifier_mode_select
                                     & cmp_now;
            o_trigger <= hit;
            o_irq     <= next_status & irq_mask;
        end
    end
endmodule

/* verification/cmpctl_chk.sv */
// port assertions of the comparator control block
`timescale 1ns/1ps
module cmpctl_chk (
    input wire logic                       i_core_clk,
    input wire logic                       i_rst,
    input wire cmpctl_pkg::cmpctl_wb_req_t i_wb,
    input wire logic [15:0]                o_wb_dat,
    input wire logic                       o_wb_ack,
    input wire logic                       i_cmp_raw,
    input wire logic                       o_comparator_output_pin,
    input wire logic                       o_trigger,
    input wire logic                       o_irq,
    input wire cmpctl_pkg::cmpctl_analog_t o_analog
);
    import cmpctl_pkg::*;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_req;
        i_wb.cyc && i_wb.stb && !o_wb_ack;
    endsequence
    AST_ACK_REQ: assert property (s_req |=> o_wb_ack)
        else $error("request not acked");
    AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 16'h0000)
        else $error("read data outside ack");
    AST_RSV_ZERO: assert property (o_wb_ack |-> o_wb_dat[12:11] == 2'b00)
        else $error("unused bits not zero");
    AST_AMP_PIN: assert property (o_analog.amp_mode |-> !o_comparator_output_pin)
        else $error("pin driven in amp mode");
    AST_OFF_PIN: assert property (!o_analog.analog_enable |-> !o_comparator_output_pin)
        else $error("pin driven while off");
    AST_TRIG_ONE: assert property (o_trigger |=> !o_trigger)
        else $error("trigger not blocked");
    AST_ADC_AMP: assert property (o_analog.adc_use_amp == o_analog.amp_mode)
        else $error("adc source wrong");
    AST_NO_GND: assert property (!o_analog.inv_input_gnd && !o_analog.noninv_input_gnd)
        else $error("available input grounded");
endmodule

bind cmpctl_top cmpctl_chk u_chk (.i_core_clk, .i_rst, .i_wb, .o_wb_dat, .o_wb_ack, .i_cmp_raw,
    .o_comparator_output_pin, .o_trigger, .o_irq, .o_analog);

/* verification/cmpctl_far.sv */
// behavioural analog comparator behind the control block
`timescale 1ns/1ps
module cmpctl_far (
    input wire cmpctl_pkg::cmpctl_analog_t i_analog,
    input wire logic [3:0]                 i_vin_p,
    input wire logic [3:0]                 i_vin_n,
    output logic                           o_cmp_raw
);
    import cmpctl_pkg::*;
    logic [3:0] vp;
    logic [3:0] vn;
    assign vp = i_analog.noninv_input_gnd ? 4'h0 : i_vin_p;
    assign vn = i_analog.inv_input_gnd ? 4'h0 : i_vin_n;
    // an amplifier or powered-down circuit gives no compare level
    assign o_cmp_raw = i_analog.analog_enable & ~i_analog.amp_mode & (vp > vn);
endmodule

/* verification/tb.sv */
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`include "cmpctl_cfg.svh"
module tb;
    import cmpctl_pkg::*;
    localparam logic [3:0] a_ctl = `CMPCTL_ADR_CONTROL;
    localparam logic [3:0] a_sts = `CMPCTL_ADR_IRQ_STATUS;
    localparam logic [3:0] a_msk = `CMPCTL_ADR_IRQ_MASK;
    logic           clk;
    logic           rst;
    cmpctl_wb_req_t wb_q;
    logic [15:0]    wdat;
    logic [15:0]    rd;
    logic           ack, raw, pin, trig, irq;
    cmpctl_analog_t ana;
    logic [3:0]     vp;
    logic [3:0]     vn;
    int             n_errors = 0;
    int             check_count = 0;
    int             trig_n = 0;
    cmpctl_top DUT (.i_core_clk(clk), .i_rst(rst), .i_wb(wb_q), .o_wb_dat(wdat), .o_wb_ack(ack),
        .i_cmp_raw(raw), .o_comparator_output_pin(pin), .o_trigger(trig), .o_irq(irq),
        .o_analog(ana));
    cmpctl_far u_far (.i_analog(ana), .i_vin_p(vp), .i_vin_n(vn), .o_cmp_raw(raw));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (trig === 1'b1) trig_n <= trig_n + 1;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // request held until ack is sampled, then idle one cycle
    task wb(input logic [3:0] a, input logic [15:0] d, input logic w);
        wb_q <= '{a, d, 2'b11, w, 1'b1, 1'b1};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = wdat;
        wb_q <= '0;
        @(posedge clk);
    endtask
    // six cycles cover the input synchroniser
    task setc(input logic [15:0] d, input logic res, input logic p);
        wb(a_ctl, d, 1'b1);
        repeat (6) @(posedge clk);
        wb(a_ctl, 16'h0000, 1'b0);
        check(rd[8], res);
        check(pin, p);
    endtask
    task t_regs;
        wb(a_ctl, 16'h0000, 1'b0);
        check(rd, `CMPCTL_CTRL_RESET);
        wb(a_sts, 16'h0000, 1'b0);
        check(rd, 16'h0000);
        wb(4'hC, 16'hFFFF, 1'b1);
        wb(4'hC, 16'h0000, 1'b0);
        check(rd, 16'h0000);
        wb(a_msk, 16'hFFFF, 1'b1);
        wb(a_msk, 16'h0000, 1'b0);
        check(rd, 16'h0001);
        vp <= 4'h9;
        setc(16'hFF3F, 1'b0, 1'b0);
        check(rd, 16'hE413);
        check(ana, 8'hF5);
    endtask
    task t_cmp;
        setc(16'hC000, 1'b1, 1'b1);
        setc(16'hE000, 1'b0, 1'b0);
        setc(16'h8000, 1'b1, 1'b0);
        setc(16'h4000, 1'b0, 1'b0);
        check(ana.analog_enable, 1'b0);
        vp <= 4'h0;
    endtask
    // rise then fall per polarity; with both, the second edge must be swallowed
    task t_event;
        int n0;
        for (int ev = 0; ev < 4; ev++) begin
            wb(a_ctl, 16'h8000 | 16'(ev << 6), 1'b1);
            wb(a_sts, 16'h0001, 1'b1);
            wb(a_msk, 16'(ev != 3), 1'b1);
            n0 = trig_n;
            vp <= 4'h9;
            repeat (8) @(posedge clk);
            vp <= 4'h0;
            repeat (8) @(posedge clk);
            check(16'(trig_n - n0), 16'(ev != 0));
            wb(a_ctl, 16'h0000, 1'b0);
            check(rd[9], ev != 0);
            wb(a_sts, 16'h0000, 1'b0);
            check(rd, 16'(ev != 0));
            check(irq, ev == 1 || ev == 2);
        end
    endtask
    initial begin
        rst = 1'b1;
        wb_q = '0;
        vp = 4'h0;
        vn = 4'h5;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_cmp;
        t_event;
        end_sim;
    end
    initial begin
        #100000;
        n_errors++;
        end_sim;
    end
endmodule
